// ---- include/tuner_host_pkg.sv ----
// Notes on behaviour
// - after reset release the device waits an initialisation time of 9 ms before taking commands.
// - the slave works at both 100 kbit/s and 400 kbit/s bus rates.
// - every bus transfer moves 8-bit units, each followed by an acknowledge bit.
// - the device answers only to seven-bit slave address 0x1D and ignores all others.
// - a host write carries a command sequence of six bytes in total.
// - a command write is taken only while busy is low; anything sent while busy is high is not taken.
// - busy/error encode low/low waiting, high/low transfer finished, low/high comm error, high/high runaway.
// - a watchdog counter overflows when the processor stops servicing it and then shows runaway.
// - busy is high while reset and the initialisation wait are in progress and low once the initialisation wait has ended.
// - the error output is low during and after reset; high means an error.
package tuner_host_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned INIT_WAIT_TIME_MS = 9;
  localparam int unsigned INIT_WAIT_CYCLES = INIT_WAIT_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned WATCH_LIMIT_CYCLES = 1000000;
  localparam logic [6:0] SLAVE_ADDR = 7'h1d;
  localparam int unsigned CMD_BYTES = 6;
  localparam int unsigned BYTE_BITS = 8;
  typedef enum logic [1:0] {
    ST_WAITING,
    ST_FINISHED,
    ST_COMM_ERROR,
    ST_RUNAWAY
  } host_status_t;
  function automatic logic [1:0] status_pins(input host_status_t s);
    unique case (s)
      ST_WAITING: status_pins = 2'h0;
      ST_FINISHED: status_pins = 2'h2;
      ST_COMM_ERROR: status_pins = 2'h1;
      ST_RUNAWAY: status_pins = 2'h3;
    endcase
  endfunction : status_pins
endpackage : tuner_host_pkg

// ---- logic/i2c_byte_slave.sv ----
module i2c_byte_slave
  import tuner_host_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_accept,
  output logic o_sda_oe,
  output logic o_start,
  output logic o_stop,
  output logic o_byte_valid,
  output logic [7:0] o_byte,
  output logic o_byte_first
);
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_q;
  logic sda_q;
  logic [7:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic active_q;
  logic first_q;
  logic ack_q;
  logic scl_rise;
  logic scl_fall;

  // two stages before any logic looks at the pins
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], i_scl};
      sda_sync_q <= {sda_sync_q[0], i_sda};
      scl_q <= scl_sync_q[1];
      sda_q <= sda_sync_q[1];
    end
  end

  assign scl_rise = scl_sync_q[1] & ~scl_q;
  assign scl_fall = ~scl_sync_q[1] & scl_q;
  assign o_start = scl_q & scl_sync_q[1] & sda_q & ~sda_sync_q[1];
  assign o_stop = scl_q & scl_sync_q[1] & ~sda_q & sda_sync_q[1];

  // sampling at 100 MHz covers both bus rates
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      shift_q <= 8'h00;
      bit_cnt_q <= 4'h0;
      active_q <= 1'b0;
      first_q <= 1'b0;
      ack_q <= 1'b0;
      o_byte_valid <= 1'b0;
      o_byte <= 8'h00;
      o_byte_first <= 1'b0;
    end else begin
      o_byte_valid <= 1'b0;
      if (o_start) begin
        active_q <= 1'b1;
        first_q <= 1'b1;
        bit_cnt_q <= 4'h0;
        ack_q <= 1'b0;
      end else if (o_stop) begin
        active_q <= 1'b0;
        ack_q <= 1'b0;
      end else if (active_q && scl_rise && bit_cnt_q < 4'(BYTE_BITS)) begin
        shift_q <= {shift_q[6:0], sda_q};
        bit_cnt_q <= bit_cnt_q + 4'h1;
        if (bit_cnt_q == 4'(BYTE_BITS - 1)) begin
          o_byte_valid <= 1'b1;
          o_byte <= {shift_q[6:0], sda_q};
          o_byte_first <= first_q;
        end
      end else if (active_q && scl_fall && bit_cnt_q == 4'(BYTE_BITS)) begin
        ack_q <= i_accept; // acknowledge slot
        first_q <= 1'b0;
        bit_cnt_q <= 4'(BYTE_BITS + 1);
      end else if (active_q && scl_fall && bit_cnt_q == 4'(BYTE_BITS + 1)) begin
        ack_q <= 1'b0;
        bit_cnt_q <= 4'h0;
        active_q <= i_accept; // a nack ends our part in the transfer
      end
    end
  end

  assign o_sda_oe = ack_q;
endmodule : i2c_byte_slave

// ---- logic/tuner_host_control_port.sv ----
module tuner_host_control_port
  import tuner_host_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_WAIT_CYCLES,
  parameter int unsigned WATCH_CYCLES = WATCH_LIMIT_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_reset_in_low,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_dsp_service,
  input wire logic i_cmd_done,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_busy,
  output logic o_host_error_flag,
  output logic o_cmd_valid,
  output logic [8*CMD_BYTES-1:0] o_cmd
);
  typedef enum logic [1:0] {
    PH_RESET,
    PH_INIT,
    PH_RUN
  } phase_t;

  phase_t phase_q;
  host_status_t status_q;
  logic [1:0] rstn_sync_q;
  logic [31:0] init_cnt_q;
  logic [31:0] runaway_watch_counter_q;
  logic [2:0] byte_cnt_q;
  logic [8*CMD_BYTES-1:0] cmd_q;
  logic addressed_q;
  logic start;
  logic stop;
  logic byte_valid;
  logic [7:0] rx_byte;
  logic byte_first;
  logic accept;
  logic take;
  logic ack_ok_q;
  logic [1:0] pins;

  // host holds reset low long enough; device relies on that
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rstn_sync_q <= 2'h0;
    end else begin
      rstn_sync_q <= {rstn_sync_q[0], i_reset_in_low};
    end
  end

  // reset, then init wait, then run
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_q <= PH_RESET;
      init_cnt_q <= 32'h0;
    end else if (!rstn_sync_q[1]) begin
      phase_q <= PH_RESET;
      init_cnt_q <= 32'h0;
    end else begin
      unique case (phase_q)
        PH_RESET: phase_q <= PH_INIT;
        PH_INIT: begin
          init_cnt_q <= init_cnt_q + 32'h1;
          if (init_cnt_q == 32'(INIT_CYCLES - 1)) begin
            phase_q <= PH_RUN;
          end
        end
        PH_RUN: phase_q <= PH_RUN;
        default: phase_q <= PH_RESET;
      endcase
    end
  end

  // watchdog: a stall of the service pulse lasting WATCH_CYCLES cycles in run overflows it
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      runaway_watch_counter_q <= 32'h0;
    end else if (phase_q != PH_RUN || i_dsp_service) begin
      runaway_watch_counter_q <= 32'h0;
    end else if (runaway_watch_counter_q != 32'(WATCH_CYCLES)) begin
      runaway_watch_counter_q <= runaway_watch_counter_q + 32'h1;
    end
  end

  i2c_byte_slave u_slave (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .i_accept(accept),
    .o_sda_oe(o_sda_oe),
    .o_start(start),
    .o_stop(stop),
    .o_byte_valid(byte_valid),
    .o_byte(rx_byte),
    .o_byte_first(byte_first)
  );

  // ack address byte only on match while idle; data only while addressed
  always_comb begin
    if (byte_first) begin
      take = (rx_byte[7:1] == SLAVE_ADDR) && !rx_byte[0] && !o_busy;
    end else begin
      take = addressed_q && !o_busy && byte_cnt_q < 3'(CMD_BYTES);
    end
  end

  // ack slot comes after the count has moved on, so keep the decision made with the byte
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_ok_q <= 1'b0;
    end else if (byte_valid) begin
      ack_ok_q <= take;
    end
  end

  assign accept = ack_ok_q;

  // six-byte command collection
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      addressed_q <= 1'b0;
      byte_cnt_q <= 3'h0;
      cmd_q <= '0;
      o_cmd_valid <= 1'b0;
      o_cmd <= '0;
    end else begin
      o_cmd_valid <= 1'b0;
      if (phase_q != PH_RUN || start) begin
        addressed_q <= 1'b0;
        byte_cnt_q <= 3'h0;
      end else if (byte_valid && byte_first) begin
        addressed_q <= take;
        byte_cnt_q <= 3'h0;
      end else if (byte_valid && take) begin
        cmd_q <= {cmd_q[8*CMD_BYTES-9:0], rx_byte};
        byte_cnt_q <= byte_cnt_q + 3'h1;
        if (byte_cnt_q == 3'(CMD_BYTES - 1)) begin
          o_cmd_valid <= 1'b1;
          o_cmd <= {cmd_q[8*CMD_BYTES-9:0], rx_byte};
          addressed_q <= 1'b0;
        end
      end else if (stop) begin
        addressed_q <= 1'b0;
        byte_cnt_q <= 3'h0;
      end
    end
  end

  // status: runaway wins, a short write is an error
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      status_q <= ST_WAITING;
    end else if (phase_q != PH_RUN) begin
      status_q <= ST_WAITING;
    end else if (runaway_watch_counter_q == 32'(WATCH_CYCLES)) begin
      status_q <= ST_RUNAWAY; // sticks until reset
    end else if (status_q != ST_RUNAWAY) begin
      if (o_cmd_valid) begin
        status_q <= ST_FINISHED;
      end else if (stop && addressed_q && byte_cnt_q != 3'h0) begin
        status_q <= ST_COMM_ERROR;
      end else if (i_cmd_done && status_q == ST_FINISHED) begin
        status_q <= ST_WAITING;
      end else if (start && status_q == ST_COMM_ERROR) begin
        status_q <= ST_WAITING; // host retries
      end
    end
  end

  assign pins = status_pins(status_q);

  // busy high in reset and init; error low there
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_busy <= 1'b1;
      o_host_error_flag <= 1'b0;
    end else begin
      o_busy <= (phase_q != PH_RUN) | pins[1];
      o_host_error_flag <= (phase_q == PH_RUN) & pins[0];
    end
  end

  assign o_sda_out = 1'b0;

  property p_busy_in_reset;
    @(posedge i_ref_clk) disable iff (i_rst) (phase_q != PH_RUN) |=> o_busy;
  endproperty
  a_busy_in_reset: assert property (p_busy_in_reset) else $error("busy low before init done");

  property p_err_low_init;
    @(posedge i_ref_clk) disable iff (i_rst) (phase_q != PH_RUN) |=> !o_host_error_flag;
  endproperty
  a_err_low_init: assert property (p_err_low_init) else $error("error high during reset");

  property p_init_leaves;
    @(posedge i_ref_clk) disable iff (i_rst) $rose(phase_q == PH_RUN) |-> init_cnt_q == 32'(INIT_CYCLES);
  endproperty
  a_init_leaves: assert property (p_init_leaves) else $error("init period wrong");

  property p_busy_drops;
    @(posedge i_ref_clk) disable iff (i_rst)
      $rose(phase_q == PH_RUN) && rstn_sync_q[1] ##1 rstn_sync_q[1] |=> !o_busy;
  endproperty
  a_busy_drops: assert property (p_busy_drops) else $error("busy not released after init");

  property p_no_take_busy;
    @(posedge i_ref_clk) disable iff (i_rst) (byte_valid && !byte_first && o_busy) |=> $stable(cmd_q);
  endproperty
  a_no_take_busy: assert property (p_no_take_busy) else $error("byte taken while busy");

  property p_addr_match;
    @(posedge i_ref_clk) disable iff (i_rst) (byte_first && accept) |-> rx_byte[7:1] == SLAVE_ADDR && !rx_byte[0];
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("wrong address acked");

  property p_six_bytes;
    @(posedge i_ref_clk) disable iff (i_rst) o_cmd_valid |-> $past(byte_cnt_q) == 3'(CMD_BYTES - 1);
  endproperty
  a_six_bytes: assert property (p_six_bytes) else $error("command not six bytes");

  sequence s_overflow;
    phase_q == PH_RUN && rstn_sync_q[1] && runaway_watch_counter_q == 32'(WATCH_CYCLES);
  endsequence
  property p_runaway;
    @(posedge i_ref_clk) disable iff (i_rst) s_overflow ##1 rstn_sync_q[1] |=> o_busy && o_host_error_flag;
  endproperty
  a_runaway: assert property (p_runaway) else $error("runaway not shown");

  property p_finished;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_cmd_valid && status_q != ST_RUNAWAY && rstn_sync_q[1] ##1 rstn_sync_q[1] && phase_q == PH_RUN
      |=> o_busy;
  endproperty
  a_finished: assert property (p_finished) else $error("finished not busy");
endmodule : tuner_host_control_port

// ---- tb/host_bus_master.sv ----
// host side of the bus: open drain, scl stands high between frames
module host_bus_master (
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  task automatic start_cond();
    o_sda_oe <= 1'b0;
    #60 o_sda_oe <= 1'b1;
    #60 o_scl <= 1'b0;
  endtask : start_cond
  // 125 ns bit; data moves only while scl is low
  task automatic clock_bit(input logic b, output logic seen);
    #30 o_sda_oe <= ~b;
    #32 o_scl <= 1'b1;
    #30 seen = i_sda;
    #33 o_scl <= 1'b0;
  endtask : clock_bit
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int k = 7; k >= 0; k--) begin
      clock_bit(v[k], s);
    end
    clock_bit(1'b1, s);
    ack = (s === 1'b0);
  endtask : send_byte
  task automatic stop_cond();
    #30 o_sda_oe <= 1'b1;
    #32 o_scl <= 1'b1;
    #60 o_sda_oe <= 1'b0;
    #60;
  endtask : stop_cond
endmodule : host_bus_master

// ---- tb/tb_tuner_host_control_port.sv ----
module tb_tuner_host_control_port;
  import tuner_host_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned INIT_SIM = 50;
  localparam int unsigned WATCH_SIM = 200;
  logic ref_clk, rst, reset_in_low, dsp_service, cmd_done, kick_en;
  logic scl, host_oe, sda_out, dev_oe, busy, err, cmd_valid;
  logic [47:0] cmd, last_cmd;
  wire logic sda_line;
  int valid_count, miscompares, total_checks;
  // pull-up: line is low only while someone pulls
  assign sda_line = ~(host_oe | (dev_oe & ~sda_out));
  host_bus_master host_bus_master_i (.i_sda(sda_line), .o_scl(scl), .o_sda_oe(host_oe));
  tuner_host_control_port #(.INIT_CYCLES(INIT_SIM), .WATCH_CYCLES(WATCH_SIM)) tuner_host_control_port_i (
    .i_ref_clk(ref_clk), .i_rst(rst), .i_reset_in_low(reset_in_low), .i_scl(scl), .i_sda(sda_line),
    .i_dsp_service(dsp_service), .i_cmd_done(cmd_done), .o_sda_out(sda_out), .o_sda_oe(dev_oe),
    .o_busy(busy), .o_host_error_flag(err), .o_cmd_valid(cmd_valid), .o_cmd(cmd));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    dsp_service <= kick_en & ~dsp_service;
    if (cmd_valid === 1'b1) begin
      valid_count++;
      last_cmd = cmd;
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : check
  task automatic wait_pins(input logic [1:0] v, input int n, input string msg);
    int k;
    k = 0;
    while ({busy, err} !== v && k < n) begin
      @(posedge ref_clk);
      k++;
    end
    check({busy, err} === v, msg);
    if ({busy, err} !== v) conclude();
  endtask : wait_pins
  task automatic frame(input logic [7:0] addr, input logic [47:0] d, input int n, output int acks);
    logic a;
    host_bus_master_i.start_cond();
    host_bus_master_i.send_byte(addr, a);
    acks = int'(a);
    for (int k = 0; k < n; k++) begin
      host_bus_master_i.send_byte(d[47-8*k -: 8], a);
      acks += int'(a);
    end
    host_bus_master_i.stop_cond();
    @(posedge ref_clk);
  endtask : frame
  task automatic power_up();
    int k;
    reset_in_low <= 1'b0;
    repeat (20) @(posedge ref_clk); // scaled hold
    check(busy === 1'b1 && err === 1'b0, "pins in reset");
    reset_in_low <= 1'b1;
    k = 0;
    while (busy !== 1'b0 && k < INIT_SIM + 20) begin
      @(posedge ref_clk);
      k++;
    end
    check(k >= INIT_SIM && k <= INIT_SIM + 8, "init length");
    check(err === 1'b0, "err after init");
  endtask : power_up
  task automatic finish_cmd();
    cmd_done <= 1'b1;
    @(posedge ref_clk);
    cmd_done <= 1'b0;
    wait_pins(2'h0, 6, "not back to waiting");
  endtask : finish_cmd
  task automatic sc_address();
    int a;
    frame(8'h38, 48'h0, 2, a);
    check(a === 0, "foreign address acked");
    frame(8'h3b, 48'h0, 0, a);
    check(a === 0 && valid_count === 0, "read acked");
  endtask : sc_address
  task automatic sc_write_busy();
    int a;
    frame(8'h3a, 48'ha5c3_0f81_7e24, 6, a);
    check(a === 7 && valid_count === 1, "six-byte write");
    check(last_cmd === 48'ha5c3_0f81_7e24, "command bytes");
    check({busy, err} === 2'h2, "finished state");
    frame(8'h3a, 48'h1122_3344_5566, 6, a);
    check(a === 0 && valid_count === 1, "taken while busy");
    check(last_cmd === 48'ha5c3_0f81_7e24, "command changed");
    finish_cmd();
  endtask : sc_write_busy
  task automatic sc_abort();
    int a;
    frame(8'h3a, 48'hffff_0000_0000, 2, a);
    check(a === 3 && {busy, err} === 2'h1, "comm error state");
    frame(8'h3a, 48'h0001_8000_ff7f, 6, a);
    check(a === 7 && last_cmd === 48'h0001_8000_ff7f, "write after error");
    finish_cmd();
  endtask : sc_abort
  task automatic sc_runaway();
    int a;
    kick_en <= 1'b0;
    wait_pins(2'h3, WATCH_SIM + 20, "no runaway");
    repeat (50) @(posedge ref_clk);
    check({busy, err} === 2'h3, "runaway not sticky");
    kick_en <= 1'b1;
    power_up(); // host restarts the device
    frame(8'h3a, 48'h0f0e_0d0c_0b0a, 6, a);
    check(a === 7 && valid_count === 3, "write after restart");
  endtask : sc_runaway
  initial begin
    rst = 1'b1;
    reset_in_low = 1'b0;
    cmd_done = 1'b0;
    dsp_service = 1'b0;
    kick_en = 1'b1;
    valid_count = 0;
    miscompares = 0;
    total_checks = 0;
    repeat (10) @(posedge ref_clk);
    check(busy === 1'b1 && err === 1'b0, "pins under reset");
    rst <= 1'b0;
    power_up();
    sc_address();
    sc_write_busy();
    sc_abort();
    sc_runaway();
    conclude();
  end
endmodule : tb_tuner_host_control_port
